// file: eeprom_dev_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Serial memory model
// ==========================================================================
module eeprom_dev_model #(
  parameter logic [3:0] DEV_TYPE = 4'h6,  // Type code; value arbitrary.
  parameter int WC_NS = 300000  // Length of the self-timed write.
) (
  input wire logic i_scl,  // Serial clock
  input wire logic i_sda,  // Resolved data line
  input wire logic [2:0] i_cs,  // Select pin levels
  input wire logic i_wp,  // Array lock pin
  output logic o_sda_low  // Pulls the data line low
);
  logic [7:0] mem [8192];
  logic [7:0] pbuf [32];
  logic [31:0] pval = '0;
  logic [12:0] ptr = '0;
  logic [7:0] sh = '0;
  logic [3:0] cnt = '0;
  logic [2:0] ph = 3'h7;
  logic tx = 1'b0;
  logic ack = 1'b0;
  logic busy = 1'b0;
  logic wpend = 1'b0;
  initial begin
    o_sda_low = 1'b0;
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(negedge i_sda) if (i_scl) begin
    {cnt, tx, ack, wpend, pval} = '0;
    ph = 3'h0;
  end
  always @(posedge i_sda) if (i_scl) begin
    if (wpend && !i_wp) begin
      for (int i = 0; i < 32; i++) if (pval[i]) mem[{ptr[12:5], 5'(i)}] = pbuf[i];
      busy <= 1'b1;
      busy <= #WC_NS 1'b0;
    end
    {wpend, tx, pval} = '0;
    ph = 3'h7;
  end
  always @(posedge i_scl) begin
    if (cnt < 4'h8) begin
      if (!tx) sh = {sh[6:0], i_sda};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8 && !tx) begin
        ack = 1'b1;
        case (ph)
          3'h0: begin
            ack = sh[7:4] == DEV_TYPE && sh[3:1] == i_cs && !busy;
            ph = !ack ? 3'h7 : sh[0] ? 3'h4 : 3'h1;
          end
          3'h1: begin
            ptr[12:8] = sh[4:0];
            ph = 3'h2;
          end
          3'h2: begin
            ptr[7:0] = sh;
            ph = 3'h3;
          end
          3'h3: begin
            pbuf[ptr[4:0]] = sh;
            pval[ptr[4:0]] = 1'b1;
            ptr[4:0] = ptr[4:0] + 5'h1;
            wpend = 1'b1;
          end
          default: ack = 1'b0;
        endcase
      end
    end else begin
      cnt = 4'h0;
      ack = 1'b0;
      if (tx && i_sda) begin
        tx = 1'b0;
        ph = 3'h7;
      end else if (ph == 3'h4) begin
        tx = 1'b1;
        sh = mem[ptr];
        ptr = ptr + 13'h1;
      end
    end
  end
  // bits out when sending, line released at ack slot; when receiving, pulled low at ack slot to ack.
  always @(negedge i_scl) o_sda_low = tx ? (cnt < 4'h8 && !sh[3'(4'h7 - cnt)]) : (cnt == 4'h8 && ack);
endmodule : eeprom_dev_model

// file: eeprom_host.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
// Function
// - Write starts with Start, device code, three select bits, direction low, acked.
// - High then low word-address byte follow, each acknowledged, loading the pointer.
// - Byte write sends one data byte; Stop starts the device write cycle.
// - Page write sends up to 31 more bytes before Stop commits them.
// - Controller refuses page writes crossing a 32-byte page boundary.
// - After write Stop, repeat Start plus write control byte until acknowledged.
// - Read uses direction bit one; current, random and sequential reads exist.
// - Current read: ack control byte, one byte out, master no-ack and Stop.
// - Random read: write control, both address bytes, then repeated Start.
// - In sequential read each master ack fetches the next byte.
// - Sequential read ends with no acknowledge on the last byte, then Stop.
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h6  // Device type code; value arbitrary.
) (
  input wire logic I_CLK,  // System clock
  input wire logic I_RESET_N,  // Synchronous reset, active low
  input wire logic I_CE,  // Clock enable, freezes all state when low
  input wire logic [7:0] I_ADDR,  // Register byte address
  input wire logic [31:0] I_WDATA,  // Register write data
  input wire logic I_WR,  // Register write strobe
  input wire logic I_RD,  // Register read strobe
  output logic [31:0] O_RDATA,  // Register read data, cycle after strobe
  input wire logic I_SDA,  // Serial data line level
  output logic O_SCL,  // Serial clock driven to the device
  output logic O_SDA_O,  // Serial data drive value, always low
  output logic O_SDA_OE_N,  // Serial data pull-down enable, active low
  output logic O_WP  // Array lock pin driven to the device
);

  function automatic logic [7:0] ctrl_byte(input logic [2:0] cs, input logic rd);
    ctrl_byte = {DEV_TYPE, cs, rd};
  endfunction : ctrl_byte

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  ctrl_t ctrl_r;
  cmd_t cmd_r;
  logic [12:0] waddr_r;
  logic [12:0] ptr_r;
  logic err_nack_r, err_range_r, err_poll_r, done_r;
  logic [7:0] buf_r [0:PAGE_BYTES-1];
  logic sda_s1_r, sda_s2_r;
  eng_t eng_r;
  logic [5:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bcnt_r;
  logic [7:0] sh_r;
  logic rx_r, ack_out_r, ack_seen_r, eng_done_r;
  seq_t seq_r;
  logic pend_r, poll_pend_r;
  logic [4:0] idx_r;
  logic [7:0] polls_r;
  logic go;
  act_t act;
  logic [7:0] tx_byte;
  logic last_byte;
  logic qtick;
  logic wr_hit, buf_hit;
  cmd_t cmd_in;
  logic range_bad;

  assign qtick = (div_r == QTR_LAST);
  assign last_byte = ({1'b0, idx_r} + 6'h01) == cmd_r.len;
  assign wr_hit = I_WR && !I_ADDR[BUF_SEL_BIT];
  assign buf_hit = I_ADDR[BUF_SEL_BIT];
  assign cmd_in = '{op: I_WDATA[CMD_OP_LSB+:3], len: I_WDATA[CMD_LEN_LSB+:6]};
  assign range_bad = (cmd_in.len == 6'h00) || (cmd_in.len > PAGE_LEN) ||
                     ((cmd_in.op == OP_WRITE) &&
                      ({1'b0, waddr_r[4:0]} + cmd_in.len > PAGE_LEN));

  // ==========================================================================
  // Data line synchroniser
  // ==========================================================================
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else if (I_CE) begin
      sda_s1_r <= I_SDA;
      sda_s2_r <= sda_s1_r;
    end
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ctrl_r <= '0;
      waddr_r <= WADDR_RST;
      O_RDATA <= '0;
    end else if (I_CE) begin
      if (wr_hit && I_ADDR == REG_CTRL) begin
        ctrl_r <= '{cs: I_WDATA[CTRL_CS_LSB+:3], lock: I_WDATA[CTRL_LOCK_BIT]};
      end
      if (wr_hit && I_ADDR == REG_ADDR) begin
        waddr_r <= I_WDATA[WADDR_BITS-1:0];
      end
      O_RDATA <= '0;
      if (I_RD && buf_hit) begin
        O_RDATA <= {24'h000000, buf_r[I_ADDR[6:2]]};
      end else if (I_RD) begin
        unique case (I_ADDR)
          REG_CTRL: O_RDATA <= 32'({ctrl_r.lock, ctrl_r.cs});
          REG_ADDR: O_RDATA <= 32'(waddr_r);
          REG_CMD: O_RDATA <= 32'({cmd_r.len, 5'h00, cmd_r.op});
          REG_STAT: begin
            O_RDATA <= '0;
            O_RDATA[STAT_BUSY_BIT] <= (seq_r != S_IDLE);
            O_RDATA[STAT_NACK_BIT] <= err_nack_r;
            O_RDATA[STAT_RANGE_BIT] <= err_range_r;
            O_RDATA[STAT_POLL_BIT] <= err_poll_r;
            O_RDATA[STAT_DONE_BIT] <= done_r;
            O_RDATA[STAT_PTR_LSB+:WADDR_BITS] <= ptr_r;
          end
          default: O_RDATA <= '0;
        endcase
      end
    end
  end

  // lock pin follows the control bit, held while the sequencer is in S_STOP
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_WP <= 1'b0;
    end else if (I_CE && seq_r != S_STOP) begin
      O_WP <= ctrl_r.lock;
    end
  end

  // ==========================================================================
  // Page buffer
  // ==========================================================================
  always_ff @(posedge I_CLK) begin
    if (I_CE) begin
      if (eng_done_r && seq_r == S_READ) begin
        buf_r[idx_r] <= sh_r;
      end else if (I_WR && buf_hit && seq_r == S_IDLE) begin
        buf_r[I_ADDR[6:2]] <= I_WDATA[7:0];
      end
    end
  end

  // ==========================================================================
  // Action chosen per sequencer state
  // ==========================================================================
  always_comb begin
    act = ACT_STOP;
    tx_byte = 8'hff;
    unique case (seq_r)
      S_START, S_RSTART, S_PSTART: act = ACT_START;
      S_CTRL: begin
        act = ACT_TX;
        tx_byte = ctrl_byte(ctrl_r.cs, cmd_r.op == OP_READ_CUR);
      end
      S_PCTRL: begin
        act = ACT_TX;
        tx_byte = ctrl_byte(ctrl_r.cs, 1'b0);
      end
      // high byte first, top bits zero
      S_AHI: begin
        act = ACT_TX;
        tx_byte = {3'h0, waddr_r[12:8]};
      end
      S_ALO: begin
        act = ACT_TX;
        tx_byte = waddr_r[7:0];
      end
      S_DATA: begin
        act = ACT_TX;
        tx_byte = buf_r[idx_r];
      end
      S_CTRLR: begin
        act = ACT_TX;
        tx_byte = ctrl_byte(ctrl_r.cs, 1'b1);
      end
      S_READ: act = ACT_RX;
      S_STOP: act = ACT_STOP;
      S_IDLE: act = ACT_STOP;
    endcase
  end

  assign go = (seq_r != S_IDLE) && !pend_r;

  // ==========================================================================
  // Bit engine
  // ==========================================================================
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      eng_r <= E_IDLE;
      div_r <= '0;
      q_r <= '0;
      bcnt_r <= '0;
      sh_r <= '0;
      rx_r <= 1'b0;
      ack_out_r <= 1'b0;
      ack_seen_r <= 1'b0;
      eng_done_r <= 1'b0;
      O_SCL <= 1'b1;
      O_SDA_O <= 1'b0;
      O_SDA_OE_N <= 1'b1;
    end else if (I_CE) begin
      eng_done_r <= 1'b0;
      if (eng_r == E_IDLE) begin
        div_r <= '0;
        q_r <= '0;
        bcnt_r <= '0;
        if (go) begin
          sh_r <= tx_byte;
          rx_r <= (act == ACT_RX);
          // acknowledge all but the last byte
          ack_out_r <= !last_byte;
          unique case (act)
            ACT_START: eng_r <= E_START;
            ACT_STOP: eng_r <= E_STOP;
            ACT_TX, ACT_RX: eng_r <= E_BIT;
          endcase
        end
      end else begin
        div_r <= qtick ? 6'h00 : div_r + 6'h01;
        if (qtick) begin
          q_r <= q_r + 2'h1;
          unique case (q_r)
            2'h0: begin
              O_SCL <= (eng_r == E_START) ? O_SCL : 1'b0;
              if (eng_r == E_START) begin
                O_SDA_OE_N <= 1'b1;
              end else if (eng_r == E_STOP) begin
                O_SDA_OE_N <= 1'b0;
              end else if (bcnt_r == 4'h8) begin
                // no acknowledge on the last byte
                O_SDA_OE_N <= rx_r ? !ack_out_r : 1'b1;
              end else begin
                O_SDA_OE_N <= rx_r ? 1'b1 : sh_r[7];
              end
            end
            2'h1: O_SCL <= 1'b1;
            2'h2: begin
              if (eng_r == E_START) begin
                O_SDA_OE_N <= 1'b0;
              end else if (eng_r == E_STOP) begin
                O_SDA_OE_N <= 1'b1;
              end else if (bcnt_r == 4'h8) begin
                ack_seen_r <= !sda_s2_r;
              end else begin
                sh_r <= {sh_r[6:0], sda_s2_r};
              end
            end
            2'h3: begin
              if (eng_r != E_STOP) begin
                O_SCL <= 1'b0;
              end
              if (eng_r == E_BIT && bcnt_r != 4'h8) begin
                bcnt_r <= bcnt_r + 4'h1;
              end else begin
                eng_r <= E_IDLE;
                eng_done_r <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Command sequencer
  // ==========================================================================
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      seq_r <= S_IDLE;
      cmd_r <= '0;
      pend_r <= 1'b0;
      poll_pend_r <= 1'b0;
      idx_r <= '0;
      polls_r <= '0;
      ptr_r <= WADDR_RST;
      err_nack_r <= 1'b0;
      err_range_r <= 1'b0;
      err_poll_r <= 1'b0;
      done_r <= 1'b0;
    end else if (I_CE) begin
      if (go) begin
        pend_r <= 1'b1;
      end
      if (seq_r == S_IDLE && wr_hit && I_ADDR == REG_CMD) begin
        cmd_r <= cmd_in;
        idx_r <= '0;
        polls_r <= '0;
        err_nack_r <= 1'b0;
        err_poll_r <= 1'b0;
        done_r <= 1'b0;
        err_range_r <= range_bad && cmd_in.op != OP_POLL;
        poll_pend_r <= (cmd_in.op == OP_POLL);
        if (cmd_in.op == OP_POLL) begin
          seq_r <= S_PSTART;
        end else if (range_bad) begin
          done_r <= 1'b1;
        end else begin
          seq_r <= S_START;
        end
      end else if (eng_done_r) begin
        pend_r <= 1'b0;
        unique case (seq_r)
          S_START: seq_r <= S_CTRL;
          // no acknowledge means no device answered
          S_CTRL: begin
            if (!ack_seen_r) begin
              err_nack_r <= 1'b1;
              seq_r <= S_STOP;
            end else begin
              // current read goes straight to data
              seq_r <= (cmd_r.op == OP_READ_CUR) ? S_READ : S_AHI;
            end
          end
          S_AHI: begin
            err_nack_r <= !ack_seen_r;
            seq_r <= ack_seen_r ? S_ALO : S_STOP;
          end
          // pointer loaded from both address bytes
          S_ALO: begin
            err_nack_r <= !ack_seen_r;
            ptr_r <= waddr_r;
            // random read restarts after the address
            seq_r <= !ack_seen_r ? S_STOP : (cmd_r.op == OP_WRITE) ? S_DATA : S_RSTART;
          end
          // up to a page of data bytes
          S_DATA: begin
            // only the low five bits advance
            ptr_r[4:0] <= ptr_r[4:0] + 5'h01;
            idx_r <= idx_r + 5'h01;
            err_nack_r <= !ack_seen_r;
            // Stop after the last byte starts the write
            seq_r <= (!ack_seen_r || last_byte) ? S_STOP : S_DATA;
            poll_pend_r <= ack_seen_r && last_byte;
          end
          // repeated Start keeps the loaded pointer
          S_RSTART: seq_r <= S_CTRLR;
          S_CTRLR: begin
            err_nack_r <= !ack_seen_r;
            seq_r <= ack_seen_r ? S_READ : S_STOP;
          end
          S_READ: begin
            ptr_r <= ptr_r + 13'h0001;
            idx_r <= idx_r + 5'h01;
            seq_r <= last_byte ? S_STOP : S_READ;
          end
          S_STOP: begin
            seq_r <= poll_pend_r ? S_PSTART : S_IDLE;
            done_r <= !poll_pend_r;
          end
          S_PSTART: seq_r <= S_PCTRL;
          S_PCTRL: begin
            polls_r <= polls_r + 8'h01;
            seq_r <= S_STOP;
            if (ack_seen_r) begin
              poll_pend_r <= 1'b0;
            // give up well after the longest write cycle
            end else if (polls_r == POLL_LIMIT) begin
              poll_pend_r <= 1'b0;
              err_poll_r <= 1'b1;
            end
          end
          S_IDLE: seq_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule : eeprom_host

// file: eeprom_host_pkg.sv
package eeprom_host_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  // A quarter of the serial clock period, rounded up to whole cycles.
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
  // Longest self-timed write cycle of the device.
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  // One poll is a start, nine bits and a stop: eleven serial clock periods.
  localparam int POLL_CYC = 11 * 4 * QTR_CYC;
  // Polls allowed before giving up: twice the longest write cycle.
  localparam logic [7:0] POLL_LIMIT = 8'(2 * WRITE_CYCLE_CYC / POLL_CYC + 1);

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] BUF_BASE = 8'h80;
  localparam int BUF_SEL_BIT = 7;

  localparam int CTRL_CS_LSB = 0;
  localparam int CTRL_LOCK_BIT = 3;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_LEN_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RANGE_BIT = 2;
  localparam int STAT_POLL_BIT = 3;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_PTR_LSB = 16;

  // ==========================================================================
  // Commands and sizes
  // ==========================================================================
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ_CUR = 3'h2;
  localparam logic [2:0] OP_READ_RAND = 3'h3;
  localparam logic [2:0] OP_POLL = 3'h4;

  localparam int PAGE_BYTES = 32;
  localparam logic [5:0] PAGE_LEN = 6'h20;
  localparam int WADDR_BITS = 13;
  localparam logic [12:0] WADDR_RST = 13'h0000;

  typedef struct packed {
    logic [2:0] op;
    logic [5:0] len;
  } cmd_t;

  typedef struct packed {
    logic [2:0] cs;
    logic lock;
  } ctrl_t;

  typedef enum {ACT_START, ACT_TX, ACT_RX, ACT_STOP} act_t;
  typedef enum {E_IDLE, E_START, E_BIT, E_STOP} eng_t;
  typedef enum {
    S_IDLE, S_START, S_CTRL, S_AHI, S_ALO, S_DATA, S_RSTART, S_CTRLR, S_READ,
    S_STOP, S_PSTART, S_PCTRL
  } seq_t;

endpackage : eeprom_host_pkg

// file: eeprom_host_properties.sv
`timescale 1ns/1ns
// ==========================================================================
// Bus watcher
// ==========================================================================
module eeprom_host_properties
  import eeprom_host_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'h6  // Type code; value arbitrary.
) (
  input wire logic I_CLK,  // System clock
  input wire logic I_RESET_N,  // Reset, active low
  input wire logic [7:0] I_ADDR,  // Register address
  input wire logic [31:0] I_WDATA,  // Write data
  input wire logic I_WR,  // Write strobe
  input wire logic I_RD,  // Read strobe
  input wire logic [31:0] O_RDATA,  // Read data
  input wire logic I_SDA,  // Data line level
  input wire logic O_SCL,  // Serial clock
  input wire logic O_SDA_O,  // Data drive value
  input wire logic O_SDA_OE_N,  // Data pull enable, active low
  input wire logic O_WP  // Lock pin
);
  logic scl_d, sda_d, first, dir, lock_req;
  logic [3:0] nbit;
  logic [2:0] nbytes;
  logic [7:0] sh;
  wire scl_rise = O_SCL && !scl_d;
  wire start_det = O_SCL && scl_d && sda_d && !I_SDA;
  wire stop_det = O_SCL && scl_d && !sda_d && I_SDA;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  always_ff @(posedge I_CLK) begin
    scl_d <= O_SCL;
    sda_d <= I_SDA;
  end
  // Tracks bit and byte position within the current frame.
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N || start_det) begin
      nbit <= 4'h0;
      nbytes <= 3'h0;
      first <= 1'b1;
    end else if (scl_rise) begin
      nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
      if (nbit < 4'h8) sh <= {sh[6:0], I_SDA};
      if (nbit == 4'h8 && nbytes != 3'h7) nbytes <= nbytes + 3'h1;
      if (nbit == 4'h8) first <= 1'b0;
      if (nbit == 4'h8 && first) dir <= sh[0];
    end
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) lock_req <= 1'b0;
    else if (I_WR && I_ADDR == REG_CTRL) lock_req <= I_WDATA[CTRL_LOCK_BIT];
  end
  sequence s_ninth;
    scl_rise && nbit == 4'h8;
  endsequence
  sequence s_nack;
    s_ninth ##0 I_SDA;
  endsequence
  a_type_code: assert property (s_ninth ##0 first |-> sh[7:4] == DEV_TYPE)
    else $error("control byte type code wrong");
  a_addr_top: assert property (s_ninth ##0 (nbytes == 3'h1 && !dir) |-> sh[7:5] == 3'h0)
    else $error("high address byte top bits set");
  a_read_release: assert property (scl_rise && dir && !first && nbit != 4'h0 && nbit < 4'h8
    |-> O_SDA_OE_N)
    else $error("controller drove data line during read byte");
  a_nack_stop: assert property (s_nack |-> ##[1:300] stop_det)
    else $error("no stop after unacknowledged byte");
  a_nack_no_start: assert property (s_nack |=> !start_det until stop_det)
    else $error("start before stop after unacknowledged byte");
  a_write_poll: assert property (stop_det && !dir && nbytes > 3'h3 |-> ##[1:1000] start_det)
    else $error("no poll start after write stop");
  a_wp_follow: assert property (I_WR && I_ADDR == REG_CTRL |-> ##[1:400] O_WP == lock_req)
    else $error("lock pin does not follow control");
  a_reset_idle: assert property ($rose(I_RESET_N) |-> O_SCL && O_SDA_OE_N && !O_WP)
    else $error("bus not idle after reset");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data without read strobe");
  a_drive_low: assert property (O_SDA_O == 1'b0)
    else $error("data drive value not low");
endmodule : eeprom_host_properties

bind eeprom_host eeprom_host_properties #(.DEV_TYPE(DEV_TYPE)) i_props (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SDA(I_SDA), .O_SCL(O_SCL),
  .O_SDA_O(O_SDA_O), .O_SDA_OE_N(O_SDA_OE_N), .O_WP(O_WP)
);

// file: eeprom_host_tb_top.sv
`timescale 1ns/1ns
module eeprom_host_tb_top
  import eeprom_host_pkg::*;
;
  localparam logic [3:0] DEV = 4'h9;  // Type code; value arbitrary.
  localparam logic [2:0] CS = 3'h2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d, stat;
  logic scl, sda_o, sda_oe_n, wp, sda_low;
  int n_fail = 0;
  int n_tests = 0;
  wire sda = (sda_oe_n | sda_o) & ~sda_low;
  always #50 clk = ~clk;
  eeprom_host #(.DEV_TYPE(DEV)) i_dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_SDA(sda), .O_SCL(scl),
    .O_SDA_O(sda_o), .O_SDA_OE_N(sda_oe_n), .O_WP(wp)
  );
  eeprom_dev_model #(.DEV_TYPE(DEV), .WC_NS(300000)) i_mem (
    .i_scl(scl), .i_sda(sda), .i_cs(CS), .i_wp(wp), .o_sda_low(sda_low)
  );
  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd
  task automatic rb(input int i, input logic [7:0] e);
    rd(BUF_BASE + 8'(4 * i), d);
    chk(32'(d[7:0]), 32'(e));
  endtask : rb
  task automatic run(input logic [2:0] op, input logic [5:0] len, input logic [31:0] m,
                     input logic [31:0] e);
    wr(REG_CMD, 32'({len, 5'h0, op}));
    stat = '0;
    for (int k = 0; k < 400 && !stat[STAT_DONE_BIT]; k++) begin
      repeat (100) @(posedge clk);
      rd(REG_STAT, stat);
    end
    chk(stat & m, e);
  endtask : run
  task automatic final_report();
    $display("COUNT comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'({scl, sda_oe_n, wp}), 32'h6);
    rd(REG_STAT, d);
    chk(d, 32'h0);
    rd(8'h40, d);
    chk(d, 32'h0);
    $display("TEST reset ends");
    wr(REG_CTRL, 32'(CS));
    wr(REG_ADDR, 32'h1ffc);
    for (int i = 0; i < 4; i++) wr(BUF_BASE + 8'(4 * i), 32'ha0 + 32'(i));
    run(OP_WRITE, 6'h4, '1, 32'h1fe0_0010);
    wr(REG_ADDR, 32'h1ffe);
    run(OP_READ_RAND, 6'h4, '1, 32'h0002_0010);
    rb(0, 8'ha2);
    rb(1, 8'ha3);
    rb(2, 8'h5a);
    rb(3, 8'h5b);
    $display("TEST page write and wrapped read ends");
    wr(REG_ADDR, 32'h2);
    wr(BUF_BASE, 32'h77);
    run(OP_WRITE, 6'h1, '1, 32'h0003_0010);
    run(OP_READ_CUR, 6'h1, '1, 32'h0004_0010);
    rb(0, 8'h59);
    $display("TEST byte write and current read ends");
    wr(REG_CTRL, 32'(CS) | 32'h8);
    repeat (3) @(posedge clk);
    chk(32'(wp), 32'h1);
    wr(BUF_BASE, 32'h33);
    run(OP_WRITE, 6'h1, 32'h1f, 32'h10);
    wr(REG_CTRL, 32'(CS));
    wr(REG_ADDR, 32'h2);
    run(OP_READ_RAND, 6'h1, 32'h1f, 32'h10);
    rb(0, 8'h77);
    $display("TEST locked write ends");
    wr(REG_ADDR, 32'h1f);
    run(OP_WRITE, 6'h2, 32'h1f, 32'h14);
    run(OP_READ_RAND, 6'h0, 32'h1f, 32'h14);
    wr(REG_CTRL, 32'h5);
    run(OP_READ_CUR, 6'h1, 32'h1f, 32'h12);
    wr(REG_CTRL, 32'(CS));
    run(OP_POLL, 6'h1, 32'h1f, 32'h10);
    $display("TEST errors and poll ends");
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end
endmodule : eeprom_host_tb_top
